// ---- hw/uil_irq.v ----
// interrupt enable, priority, status and clearing logic of a fifo uart
// assumes fifo, shifter and flow-control blocks deliver level and pulse events
`include "uil_regs.vh"

module uil_irq (
    input  wire       CLK_SYS_I,
    input  wire       RESET_I,
    input  wire [2:0] ADDR_I,
    input  wire [7:0] WDATA_I,
    input  wire       WR_I,
    input  wire       RD_I,
    output wire [7:0] RDATA_O,
    input  wire       FCR_WR_I,
    input  wire [5:0] RX_FILL_I,
    input  wire [5:0] TX_FILL_I,
    input  wire [7:0] RX_DATA_I,
    input  wire       RX_PUSH_I,
    input  wire       RX_PUSH_ERR_I,
    input  wire       RX_HEAD_ADV_I,
    input  wire [2:0] RX_HEAD_ERR_I,
    input  wire       RX_ANY_ERR_I,
    input  wire       RX_OVERRUN_I,
    input  wire       TSR_EMPTY_I,
    input  wire       AUTO_DIR_I,
    input  wire       BIT_TICK_I,
    input  wire [3:0] CHAR_BITS_I,
    input  wire [3:0] MODEM_DELTA_I,
    input  wire [3:0] MODEM_STATE_I,
    input  wire       XOFF_RX_I,
    input  wire       XON_RX_I,
    input  wire       SPECIAL_RX_I,
    input  wire       RTS_RISE_I,
    input  wire       CTS_RISE_I,
    input  wire       WAKE_I,
    output wire       IRQ_O,
    output wire       RX_POP_O,
    output wire       TX_PUSH_O,
    output wire       FIFO_EN_O,
    output wire       SLEEP_EN_O,
    output wire [1:0] RX_TRIG_SEL_O
);

// ==========================================================
// level decoding
function [5:0] rx_level;
    input [1:0] sel;
    begin
        case (sel)
            2'h0:    rx_level = `UIL_RXT_0;
            2'h1:    rx_level = `UIL_RXT_1;
            2'h2:    rx_level = `UIL_RXT_2;
            default: rx_level = `UIL_RXT_3;
        endcase
    end
endfunction

function [5:0] tx_level;
    input [1:0] sel;
    begin
        case (sel)
            2'h0:    tx_level = `UIL_TXT_0;
            2'h1:    tx_level = `UIL_TXT_1;
            2'h2:    tx_level = `UIL_TXT_2;
            default: tx_level = `UIL_TXT_3;
        endcase
    end
endfunction

// ==========================================================
// access decode
wire wr_ier  = WR_I & (ADDR_I == `UIL_OFS_IER);
wire wr_thr  = WR_I & (ADDR_I == `UIL_OFS_DATA);
wire wr_efr  = WR_I & (ADDR_I == `UIL_OFS_EFR);
wire wr_xfr  = WR_I & (ADDR_I == `UIL_OFS_XFR);
wire rd_rhr  = RD_I & (ADDR_I == `UIL_OFS_DATA);
wire rd_isr  = RD_I & (ADDR_I == `UIL_OFS_ISR);
wire rd_lsr  = RD_I & (ADDR_I == `UIL_OFS_LSR);
wire rd_msr  = RD_I & (ADDR_I == `UIL_OFS_MSR);

// ==========================================================
// registers
reg [7:0] ier_ff;
reg [7:0] fcr_ff;
reg [7:0] efr_ff;
reg [7:0] xfr_ff;
reg [7:0] rdata_ff;
reg       ovr_ff;
reg       ls_ff;
reg       tx_ff;
reg       tout_ff;
reg [6:0] tcnt_ff;
reg [3:0] mdelta_ff;
reg       xoff_ff;
reg       spec_ff;
reg       rts_ff;
reg       cts_ff;
reg       wake_ff;
reg [5:0] txfill_ff;
reg       txidle_ff;

wire       enh     = efr_ff[`UIL_EFR_ENH];
wire       fifo_en = fcr_ff[`UIL_FCR_EN];
wire [5:0] rx_trig = rx_level(fcr_ff[7:6]);
wire [5:0] tx_trig = tx_level(fcr_ff[5:4]);
wire       rx_nemp = (RX_FILL_I != `UIL_FILL_ZERO);
wire       tx_emp  = (TX_FILL_I == `UIL_FILL_ZERO);
wire       tx_idle = tx_emp & TSR_EMPTY_I;

// ==========================================================
// source conditions
// rx data is a level, it withdraws as soon as the fill drops
wire rx_avail = fifo_en ? (RX_FILL_I >= rx_trig) : rx_nemp;  // [R1] [R5]

// error interrupt at receipt or when the faulty byte reaches the head
wire err_evt  = xfr_ff[`UIL_XFR_ERRRX] ? RX_PUSH_ERR_I      // [R7]
                : (RX_HEAD_ADV_I & (|RX_HEAD_ERR_I));

// tx service: crossing below level, or emptied without passing it
wire tx_below = fifo_en ? ((txfill_ff >= tx_trig) & (TX_FILL_I < tx_trig))
                : 1'b0;                                       // [R23]
wire tx_drain = tx_emp & (txfill_ff != `UIL_FILL_ZERO);
wire tx_done  = tx_idle & ~txidle_ff;
wire tx_evt   = AUTO_DIR_I ? tx_done : (tx_below | tx_drain); // [R15]
wire tx_arm   = wr_ier & WDATA_I[`UIL_IER_TX] & ~ier_ff[`UIL_IER_TX]
                & tx_emp;                                     // [R6]

// timeout limit, four char times plus twelve bit times
wire [6:0] tout_lim = (`UIL_TOUT_CHARS * {3'h0, CHAR_BITS_I})
                      + `UIL_TOUT_BITS;                       // [R14]

// ==========================================================
// gated pending sources
wire p_ls   = ier_ff[`UIL_IER_LS] & ls_ff;
wire p_tout = ier_ff[`UIL_IER_RX] & tout_ff;
wire p_rx   = ier_ff[`UIL_IER_RX] & rx_avail;                 // [R5]
wire p_tx   = ier_ff[`UIL_IER_TX] & tx_ff;                    // [R6]
wire p_ms   = ier_ff[`UIL_IER_MS] & (|mdelta_ff);             // [R8]
wire p_xoff = enh & ier_ff[`UIL_IER_XOFF] & (xoff_ff | spec_ff); // [R18]
wire p_flow = enh & ((ier_ff[`UIL_IER_RTS] & rts_ff)          // [R10]
                   | (ier_ff[`UIL_IER_CTS] & cts_ff));        // [R11]
wire any_p  = p_ls | p_tout | p_rx | p_tx | p_ms | p_xoff | p_flow;

// ==========================================================
// priority encoder: only the top source is shown
reg [5:0] code;
reg [2:0] top;

always @* begin
    code = `UIL_CODE_NONE;                                    // [R20]
    top  = 3'h0;
    if (p_ls) begin                                           // [R12] [R13]
        code = `UIL_CODE_LS;
        top  = 3'h1;
    end else if (p_tout) begin
        code = `UIL_CODE_TOUT;
        top  = 3'h2;
    end else if (p_rx) begin
        code = `UIL_CODE_RX;
        top  = 3'h3;
    end else if (p_tx) begin
        code = `UIL_CODE_TX;
        top  = 3'h4;
    end else if (p_ms) begin
        code = `UIL_CODE_MS;
        top  = 3'h5;
    end else if (p_xoff) begin
        code = `UIL_CODE_XOFF;
        top  = 3'h6;
    end else if (p_flow) begin
        code = `UIL_CODE_FLOW;
        top  = 3'h7;
    end
end

wire [7:0] isr_val = {fifo_en, fifo_en, code};                // [R21]

// status read only acknowledges what it reported
wire ack_tx   = rd_isr & (top == 3'h4);                       // [R15]
wire ack_xoff = rd_isr & (top == 3'h6);                       // [R17]

// ==========================================================
// line status, polled view independent of the enables
wire [7:0] lsr_val = {fifo_en & RX_ANY_ERR_I, tx_idle, tx_emp,
                      RX_HEAD_ERR_I, ovr_ff, rx_nemp};        // [R2] [R3] [R4]

// ==========================================================
// enable, fifo control, feature registers
always @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
        ier_ff <= `UIL_IER_RST;                               // [R9]
        fcr_ff <= `UIL_FCR_RST;                               // [R22]
        efr_ff <= `UIL_ZERO8;
        xfr_ff <= `UIL_ZERO8;
    end else begin
        if (wr_ier) begin
            // upper enables keep their value while enhanced mode is off
            ier_ff <= enh ? WDATA_I
                      : ((WDATA_I & `UIL_IER_LO_MSK)
                         | (ier_ff & ~`UIL_IER_LO_MSK));      // [R9]
        end
        if (FCR_WR_I) begin
            if (~WDATA_I[`UIL_FCR_EN]) begin
                fcr_ff <= `UIL_FCR_RST;
            end else if (enh) begin
                fcr_ff <= WDATA_I;                            // [R23]
            end else begin
                fcr_ff <= (WDATA_I & ~`UIL_FCR_KEEP)
                          | (fcr_ff & `UIL_FCR_KEEP);
            end
        end
        if (wr_efr) begin
            efr_ff <= WDATA_I;
        end
        if (wr_xfr & enh) begin
            xfr_ff <= WDATA_I;
        end
    end
end

// ==========================================================
// sticky sources: set always wins over a clear in the same cycle
always @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
        ovr_ff    <= 1'b0;
        ls_ff     <= 1'b0;
        tx_ff     <= 1'b0;
        mdelta_ff <= 4'h0;
        xoff_ff   <= 1'b0;
        spec_ff   <= 1'b0;
        rts_ff    <= 1'b0;
        cts_ff    <= 1'b0;
        wake_ff   <= 1'b0;
        txfill_ff <= `UIL_FILL_ZERO;
        txidle_ff <= 1'b1;
    end else begin
        ovr_ff    <= RX_OVERRUN_I | (ovr_ff & ~rd_lsr);       // [R4]
        ls_ff     <= RX_OVERRUN_I | err_evt
                     | (ls_ff & ~rd_lsr);                     // [R7] [R16]
        tx_ff     <= tx_evt | tx_arm
                     | (tx_ff & ~ack_tx & ~wr_thr);           // [R15]
        mdelta_ff <= MODEM_DELTA_I | (mdelta_ff & {4{~rd_msr}}); // [R16]
        xoff_ff   <= XOFF_RX_I
                     | (xoff_ff & ~XON_RX_I & ~ack_xoff);     // [R17]
        // the special char itself arrives with a push, so set dominates
        spec_ff   <= SPECIAL_RX_I
                     | (spec_ff & ~RX_PUSH_I & ~ack_xoff);    // [R17]
        rts_ff    <= RTS_RISE_I | (rts_ff & ~rd_msr);         // [R10] [R16]
        cts_ff    <= CTS_RISE_I | (cts_ff & ~rd_msr);         // [R11] [R16]
        wake_ff   <= WAKE_I | (wake_ff & ~rd_isr);            // [R19]
        txfill_ff <= TX_FILL_I;
        txidle_ff <= tx_idle;
    end
end

// ==========================================================
// receive timeout counter in bit times
always @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
        tcnt_ff <= `UIL_CNT_ZERO;
        tout_ff <= 1'b0;
    end else begin
        // any push or rhr read restarts the wait
        if (RX_PUSH_I | rd_rhr | ~rx_nemp | ~fifo_en) begin
            tcnt_ff <= `UIL_CNT_ZERO;
        end else if (BIT_TICK_I & (tcnt_ff < tout_lim)) begin
            tcnt_ff <= tcnt_ff + `UIL_CNT_ONE;
        end
        if (rx_nemp & fifo_en & (tcnt_ff >= tout_lim)
            & ~RX_PUSH_I & ~rd_rhr) begin
            tout_ff <= 1'b1;                                  // [R14]
        end else if (rd_rhr | ~fifo_en) begin
            tout_ff <= 1'b0;                                  // [R14]
        end
    end
end

// ==========================================================
// read data, one cycle after the strobe; unmapped reads zero
reg [7:0] nxt_rdata;

always @* begin
    nxt_rdata = `UIL_ZERO8;
    case (ADDR_I)
        `UIL_OFS_DATA: nxt_rdata = RX_DATA_I;
        `UIL_OFS_IER:  nxt_rdata = enh ? ier_ff
                                   : (ier_ff & `UIL_IER_LO_MSK); // [R9]
        `UIL_OFS_ISR:  nxt_rdata = isr_val;                   // [R12]
        `UIL_OFS_LSR:  nxt_rdata = lsr_val;                   // [R3]
        `UIL_OFS_MSR:  nxt_rdata = {MODEM_STATE_I, mdelta_ff};
        `UIL_OFS_EFR:  nxt_rdata = efr_ff;
        `UIL_OFS_XFR:  nxt_rdata = xfr_ff;
        default:       nxt_rdata = `UIL_ZERO8;
    endcase
end

always @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
        rdata_ff <= `UIL_ZERO8;
    end else if (RD_I) begin
        rdata_ff <= nxt_rdata;
    end else begin
        rdata_ff <= `UIL_ZERO8;
    end
end

// ==========================================================
// outputs
// wake-up raises the line but leaves status bit 0 high
assign IRQ_O         = any_p | wake_ff;                       // [R24] [R19]
assign RDATA_O       = rdata_ff;
assign RX_POP_O      = rd_rhr;
assign TX_PUSH_O     = wr_thr;
assign FIFO_EN_O     = fifo_en;
assign SLEEP_EN_O    = enh & ier_ff[`UIL_IER_SLEEP];
assign RX_TRIG_SEL_O = fcr_ff[7:6];

endmodule

// ---- hw/uil_regs.vh ----
// constants of the uart interrupt logic: register map, fields, codes, levels
// assumes a byte-wide register port with one-cycle strobes, rx/tx fifos of 32
// Notes on behaviour
// R1: with fifos and rx enable, rx interrupt tracks fill at or above trigger
// R2: data-ready flag set on first char pushed, cleared when rx fifo empty
// R3: fifos on and enables 3..0 clear gives polled mode via line status
// R4: line status shows overrun, head errors, thr empty, tx idle, fifo error
// R5: enable bit 0 gates rx data interrupt, holding char or trigger level
// R6: enable bit 1 gates tx ready; fires at once if thr already empty
// R7: overrun interrupts on receipt; other errors at head or receipt per xfr bit 3
// R8: enable bit 3 raises modem interrupt when any modem delta bit sets
// R9: enable bits 7..4 reachable only with efr bit 4; all reset to zero
// R10: enable bit 6 interrupts on auto-flow rts rising edge
// R11: enable bit 7 interrupts on auto-flow cts rising edge
// R12: status read shows only the highest pending source, rest stay queued
// R13: status bits 5..0 carry the seven priority codes, idle reads 000001
// R14: rx timeout after four chars plus twelve bits, cleared by rhr read
// R15: tx ready from trigger/empty or tx idle in auto direction; status read or thr write clears
// R16: line status read clears line irq; modem read clears modem and rts/cts
// R17: xoff cleared by status read or xon; special by read or next char
// R18: status bits 5..4 need efr bit 4; xoff bit holds until xon or a status read that reports it
// R19: wake-up shows as interrupt with code 000001, cleared by status read
// R20: status bit 0 low while pending, high when idle or after wake-up
// R21: status bits 7..6 mirror the fifo enable
// R22: rx trigger field selects 8, 16, 24 or 28, default 8
// R23: tx trigger field 16, 8, 24, 30; request below level or on empty
// R24: interrupt output active whenever a source is pending
// R25: host reads status first, then does the matching clearing access
`ifndef UIL_REGS_VH
`define UIL_REGS_VH

// ==========================================================
// register offsets
`define UIL_OFS_DATA    3'h0
`define UIL_OFS_IER     3'h1
`define UIL_OFS_ISR     3'h2
`define UIL_OFS_LSR     3'h3
`define UIL_OFS_MSR     3'h4
`define UIL_OFS_EFR     3'h5
`define UIL_OFS_XFR     3'h6

// ==========================================================
// fields
`define UIL_EFR_ENH     4
`define UIL_XFR_ERRRX   3
`define UIL_FCR_EN      0
`define UIL_IER_RX      0
`define UIL_IER_TX      1
`define UIL_IER_LS      2
`define UIL_IER_MS      3
`define UIL_IER_SLEEP   4
`define UIL_IER_XOFF    5
`define UIL_IER_RTS     6
`define UIL_IER_CTS     7
`define UIL_IER_LO_MSK  8'h0F
`define UIL_IER_RST     8'h00
`define UIL_FCR_RST     8'h00
`define UIL_FCR_KEEP    8'h30
`define UIL_ZERO8       8'h00

// ==========================================================
// status codes, bits 5..0
`define UIL_CODE_LS     6'h06
`define UIL_CODE_TOUT   6'h0C
`define UIL_CODE_RX     6'h04
`define UIL_CODE_TX     6'h02
`define UIL_CODE_MS     6'h00
`define UIL_CODE_XOFF   6'h10
`define UIL_CODE_FLOW   6'h20
`define UIL_CODE_NONE   6'h01

// ==========================================================
// trigger levels and timeout
`define UIL_RXT_0       6'h08
`define UIL_RXT_1       6'h10
`define UIL_RXT_2       6'h18
`define UIL_RXT_3       6'h1C
`define UIL_TXT_0       6'h10
`define UIL_TXT_1       6'h08
`define UIL_TXT_2       6'h18
`define UIL_TXT_3       6'h1E
`define UIL_TOUT_CHARS  7'h04
`define UIL_TOUT_BITS   7'h0C
`define UIL_FILL_ZERO   6'h00
`define UIL_CNT_ZERO    7'h00
`define UIL_CNT_ONE     7'h01

`endif

// ---- sim/uil_dp_model.sv ----
// model of the uart datapath around the interrupt logic: fifo fills, bit tick
// assumes pushes come from the bench, pops and loads from the block's strobes
module uil_dp_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       push_i,
    input  wire logic       pop_i,
    input  wire logic       load_i,
    output logic      [5:0] rx_fill_o,
    output logic      [5:0] tx_fill_o,
    output logic            tick_o,
    output logic            tsr_empty_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_ff;
    logic [5:0] rx_ff;
    logic [5:0] tx_ff;
    // ==========================================================
    // fills; tick every 8 clocks keeps the timeout short
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_ff <= 3'h0;
            rx_ff  <= 6'h00;
            tx_ff  <= 6'h00;
        end else begin
            div_ff <= div_ff + 3'h1;
            rx_ff  <= rx_ff + {5'h00, push_i && rx_ff != 6'h20} - {5'h00, pop_i && rx_ff != 6'h00};
            tx_ff  <= tx_ff + {5'h00, load_i} - {5'h00, tick_o && tx_ff != 6'h00};
        end
    end
    assign tick_o      = div_ff == 3'h7;
    assign rx_fill_o   = rx_ff;
    assign tx_fill_o   = tx_ff;
    assign tsr_empty_o = tx_ff == 6'h00;
endmodule

// ---- sim/uil_irq_monitor.sv ----
// checker of uil_irq: read slot timing, status codes, control outputs
// assumes it is bound to the top module and sees only its ports
module uil_irq_monitor (
    input wire logic       CLK_SYS_I,
    input wire logic       RESET_I,
    input wire logic [2:0] ADDR_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       FCR_WR_I,
    input wire logic [2:0] RX_HEAD_ERR_I,
    input wire logic       RX_ANY_ERR_I,
    input wire logic       IRQ_O,
    input wire logic       RX_POP_O,
    input wire logic       TX_PUSH_O,
    input wire logic       FIFO_EN_O,
    input wire logic       SLEEP_EN_O,
    input wire logic [1:0] RX_TRIG_SEL_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    wire rd_isr = RD_I && ADDR_I == 3'h2;
    wire rd_lsr = RD_I && ADDR_I == 3'h3;
    // ==========================================================
    // assertions
    a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data outside the read slot");
    a_isr_fifo: assert property ($past(rd_isr) |-> RDATA_O[7:6] == {2{$past(FIFO_EN_O)}})
        else $error("status bits 7..6 differ from fifo enable");
    a_isr_code: assert property ($past(rd_isr) |->
        RDATA_O[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
        else $error("illegal status code");
    a_isr_idle: assert property ($past(rd_isr && !IRQ_O) |-> RDATA_O[5:0] == 6'h01)
        else $error("status not idle without interrupt");
    a_irq_match: assert property ($past(rd_isr) && RDATA_O[5:0] != 6'h01 |-> $past(IRQ_O))
        else $error("pending code without interrupt output");
    a_lsr_err: assert property ($past(rd_lsr) |->
        RDATA_O[7] == $past(RX_ANY_ERR_I) && RDATA_O[4:2] == $past(RX_HEAD_ERR_I))
        else $error("line status error bits wrong");
    a_pop_strobe: assert property (RX_POP_O == (RD_I && ADDR_I == 3'h0))
        else $error("rx pop not tied to data read");
    a_push_strobe: assert property (TX_PUSH_O == (WR_I && ADDR_I == 3'h0))
        else $error("tx push not tied to data write");
    a_fcr_only: assert property ($changed({FIFO_EN_O, RX_TRIG_SEL_O}) |-> $past(FCR_WR_I))
        else $error("fifo control changed without write");
    a_sleep_gate: assert property ($rose(SLEEP_EN_O) |->
        $past(WR_I && (ADDR_I == 3'h1 || ADDR_I == 3'h5)))
        else $error("sleep enable rose without write");
    c_line: cover property ($past(rd_isr) && RDATA_O[5:0] == 6'h06);
    c_tout: cover property ($past(rd_isr) && RDATA_O[5:0] == 6'h0C);
    c_flow: cover property ($past(rd_isr) && RDATA_O[5:0] == 6'h20);
endmodule

bind uil_irq uil_irq_monitor mon_u (.CLK_SYS_I, .RESET_I, .ADDR_I, .WR_I, .RD_I, .RDATA_O, .FCR_WR_I,
    .RX_HEAD_ERR_I, .RX_ANY_ERR_I, .IRQ_O, .RX_POP_O, .TX_PUSH_O, .FIFO_EN_O, .SLEEP_EN_O, .RX_TRIG_SEL_O);

// ---- sim/uil_irq_tb.sv ----
// self-checking bench of uil_irq with a datapath model
// assumes a 100 MHz clock and the register map of uil_regs.vh
module uil_irq_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] interrupt_enable;
        logic [7:0] enhanced_feature_reg;
        logic [3:0] evb;
        logic [7:0] code;
        logic [2:0] clr;
    } uil_row_t;
    logic       clk, rst, wr_s, rd, fcr_wr, irq, pop, load, fifo_en, sleep, tick, tsr_e;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, lvl;
    logic [10:0] evt;
    logic [5:0] rx_fill, tx_fill;
    logic [1:0] rx_sel;
    int         n_errors = 0;
    int         samples_checked = 0;
    logic [7:0] fcrs [5] = '{8'h00, 8'h01, 8'h41, 8'h81, 8'hC1};
    int         trig [5] = '{1, 8, 16, 24, 28};
    uil_row_t   rows [6] = '{'{8'h08, 8'h00, 4'h1, 8'hC0, 3'h4}, '{8'h40, 8'h10, 4'h2, 8'hE0, 3'h4},
        '{8'h80, 8'h10, 4'h3, 8'hE0, 3'h4}, '{8'h20, 8'h10, 4'h4, 8'hD0, 3'h2},
        '{8'h20, 8'h10, 4'h6, 8'hD0, 3'h2}, '{8'h04, 8'h00, 4'h0, 8'hC6, 3'h3}};

    uil_irq dut_u (
        .CLK_SYS_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd),
        .RDATA_O(rdata), .FCR_WR_I(fcr_wr), .RX_FILL_I(rx_fill), .TX_FILL_I(tx_fill),
        .RX_DATA_I({2'h0, rx_fill}), .RX_PUSH_I(evt[10]), .RX_PUSH_ERR_I(evt[8]),
        .RX_HEAD_ADV_I(evt[9]), .RX_HEAD_ERR_I(lvl[6:4]), .RX_ANY_ERR_I(lvl[7]), .RX_OVERRUN_I(evt[0]),
        .TSR_EMPTY_I(tsr_e), .AUTO_DIR_I(1'h0), .BIT_TICK_I(tick), .CHAR_BITS_I(4'hA),
        .MODEM_DELTA_I({3'h0, evt[1]}), .MODEM_STATE_I(lvl[3:0]), .XOFF_RX_I(evt[4]), .XON_RX_I(evt[5]),
        .SPECIAL_RX_I(evt[6]), .RTS_RISE_I(evt[2]), .CTS_RISE_I(evt[3]), .WAKE_I(evt[7]), .IRQ_O(irq),
        .RX_POP_O(pop), .TX_PUSH_O(load), .FIFO_EN_O(fifo_en), .SLEEP_EN_O(sleep), .RX_TRIG_SEL_O(rx_sel));
    uil_dp_model dp_u (.clk_i(clk), .rst_i(rst), .push_i(evt[10]), .pop_i(pop), .load_i(load),
        .rx_fill_o(rx_fill), .tx_fill_o(tx_fill), .tick_o(tick), .tsr_empty_o(tsr_e));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // bus and check tasks; one idle edge between strobes
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d, input logic f);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_s   <= !f;
        fcr_wr <= f;
        @(posedge clk);
        wr_s   <= 1'h0;
        fcr_wr <= 1'h0;
        // let the write settle before any direct look at irq or sleep
        #1;
    endtask
    task rc(input logic [2:0] a, input logic [7:0] e, input logic cmp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk);
        rd   <= 1'h0;
        #1;
        if (cmp) chk(rdata, e);
    endtask
    task ev(input int n);
        @(posedge clk);
        evt[n] <= 1'h1;
        @(posedge clk);
        evt[n] <= 1'h0;
        #1;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
    // ==========================================================
    // main sequence
    initial begin
        int i;
        int tout;
        rst = 1'h1; addr = 3'h0; wdata = 8'h00; wr_s = 1'h0; rd = 1'h0; fcr_wr = 1'h0; evt = '0; lvl = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        rc(3'h1, 8'h00, 1'h1);
        rc(3'h2, 8'h01, 1'h1);
        chk({7'h00, fifo_en}, 8'h00);
        wr(3'h1, 8'hFF, 1'h0);
        rc(3'h1, 8'h0F, 1'h1);
        chk({7'h00, irq}, 8'h01);
        rc(3'h2, 8'h02, 1'h1);
        rc(3'h2, 8'h01, 1'h1);
        wr(3'h1, 8'h00, 1'h0);
        $display("test reset and enables done");
        for (int r = 0; r < 5; r++) begin
            wr(3'h0, fcrs[r], 1'h1);
            wr(3'h1, 8'h01, 1'h0);
            repeat (trig[r] - 1) ev(10);
            rc(3'h2, {{2{fcrs[r][0]}}, 6'h01}, 1'h1);
            ev(10);
            rc(3'h2, {{2{fcrs[r][0]}}, 6'h04}, 1'h1);
            chk({6'h00, rx_sel}, {6'h00, fcrs[r][7:6]});
            rc(3'h0, 8'h00, 1'h0);
            rc(3'h2, {{2{fcrs[r][0]}}, 6'h01}, 1'h1);
            repeat (trig[r] - 1) rc(3'h0, 8'h00, 1'h0);
            wr(3'h1, 8'h00, 1'h0);
        end
        $display("test trigger levels done");
        wr(3'h0, 8'h01, 1'h1);
        lvl <= 8'hF5;
        ev(10);
        rc(3'h3, 8'hFD, 1'h1);
        chk({7'h00, irq}, 8'h00);
        rc(3'h0, 8'h00, 1'h0);
        rc(3'h3, 8'hFC, 1'h1);
        lvl <= 8'h00;
        wr(3'h1, 8'h07, 1'h0);
        ev(0);
        rc(3'h2, 8'hC6, 1'h1);
        rc(3'h2, 8'hC6, 1'h1);
        rc(3'h3, 8'h62, 1'h1);
        rc(3'h2, 8'hC2, 1'h1);
        rc(3'h2, 8'hC1, 1'h1);
        $display("test priority done");
        tout = (4 * 10 + 12) * 8;
        wr(3'h1, 8'h01, 1'h0);
        ev(10);
        for (i = 0; i < 1000 && irq !== 1'h1; i++) @(posedge clk);
        if (i == 1000) begin
            n_errors++;
            end_of_test;
        end
        chk({7'h00, i >= tout - 16 && i <= tout + 16}, 8'h01);
        #1;
        rc(3'h2, 8'hCC, 1'h1);
        rc(3'h0, 8'h00, 1'h0);
        rc(3'h2, 8'hC1, 1'h1);
        $display("test timeout done");
        foreach (rows[r]) begin
            wr(3'h5, rows[r].enhanced_feature_reg, 1'h0);
            wr(3'h1, rows[r].interrupt_enable, 1'h0);
            ev(rows[r].evb);
            chk({7'h00, irq}, 8'h01);
            rc(3'h2, rows[r].code, 1'h1);
            rc(rows[r].clr, 8'h00, 1'h0);
            rc(3'h2, 8'hC1, 1'h1);
            chk({7'h00, irq}, 8'h00);
        end
        $display("test source rows done");
        wr(3'h5, 8'h10, 1'h0);
        wr(3'h1, 8'h20, 1'h0);
        ev(4);
        ev(5);
        rc(3'h2, 8'hC1, 1'h1);
        wr(3'h1, 8'h10, 1'h0);
        chk({7'h00, sleep}, 8'h01);
        ev(7);
        chk({7'h00, irq}, 8'h01);
        rc(3'h2, 8'hC1, 1'h1);
        chk({7'h00, irq}, 8'h00);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        rc(3'h1, 8'h00, 1'h1);
        rc(3'h2, 8'h01, 1'h1);
        $display("test wake and second reset done");
        end_of_test;
    end
endmodule
